//--- pkg/crpr_pkg.sv
// constants and types shared by the cable reflection peak result bank
package crpr_pkg;

	// bus and register geometry
	localparam int CRPR_DATA_W = 32;
	localparam int CRPR_ADDR_W = 12;
	localparam int CRPR_IDX_W = 10;
	localparam int CRPR_POS_W = 8;
	localparam int CRPR_MAG_W = 7;
	localparam int CRPR_POS_N = 4;
	localparam int CRPR_MAG_N = 10;

	// register indexes, byte address is four times the index
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_POS_D_LO = 10'h198;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_POS_D_HI = 10'h199;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_MAG_A_1 = 10'h19A;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_MAG_A_2 = 10'h19B;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_MAG_AB = 10'h19C;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_MAG_B_1 = 10'h19D;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_MAG_B_2 = 10'h19E;
	localparam logic [CRPR_IDX_W-1:0] CRPR_IDX_CTRL = 10'h1B0;

	// field positions
	localparam int CRPR_HI_LSB = 8;
	localparam int CRPR_LO_LSB = 0;
	localparam int CRPR_CTRL_HOLD_BIT = 0;
	localparam int CRPR_STAT_VALID_BIT = 8;
	localparam int CRPR_STAT_MISS_BIT = 9;

	// values after reset
	localparam logic [CRPR_POS_W-1:0] CRPR_POS_RST = 8'h00;
	localparam logic [CRPR_MAG_W-1:0] CRPR_MAG_RST = 7'h00;
	localparam logic [CRPR_DATA_W-1:0] CRPR_RDATA_RST = 32'h0000_0000;

	// bus phase tracker
	typedef enum logic [2:0] {
		CRPR_ST_IDLE = 3'b001,
		CRPR_ST_SETUP = 3'b010,
		CRPR_ST_ACCESS = 3'b100
	} crpr_apb_state_e;

endpackage

//--- src/crpr_apb_fsm.sv
// phase tracker for the apb slave port, zero wait states
`timescale 1ns/10ps
module crpr_apb_fsm (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb control
	input wire logic psel,
	input wire logic penable,
	// phase outputs
	output crpr_pkg::crpr_apb_state_e state_q,
	output logic setup_take,
	output logic pready
);
	import crpr_pkg::*;

	crpr_apb_state_e state_d;

	always_comb begin
		case (state_q)
			CRPR_ST_IDLE, CRPR_ST_ACCESS: begin
				state_d = (psel && !penable) ? CRPR_ST_SETUP : CRPR_ST_IDLE;
			end
			CRPR_ST_SETUP: begin
				state_d = (psel && penable) ? CRPR_ST_ACCESS : CRPR_ST_IDLE;
			end
			default: begin
				state_d = CRPR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CRPR_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// read data is captured in the setup cycle so the access phase never waits
	assign setup_take = psel && !penable;
	assign pready = psel && penable;

endmodule

//--- src/crpr_peak_store.sv
// bank of result fields loaded as a whole by the reflectometry engine
`timescale 1ns/10ps
module crpr_peak_store #(
	parameter int N = 4,
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// load from the engine
	input wire logic load_en,
	input wire logic [N*W-1:0] load_data,
	// stored fields
	output logic [N*W-1:0] fields_q
);
	import crpr_pkg::*;

	logic [N*W-1:0] fields_d;

	// only a completed test replaces the fields; reads never touch them
	always_comb begin
		fields_d = fields_q;
		if (load_en) begin
			fields_d = load_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fields_q <= {N{RST}};
		end else begin
			fields_q <= fields_d;
		end
	end

endmodule

//--- src/crpr_top.sv
// cable reflection peak result bank with apb register access
//
// How it works
// - index 0x198 holds channel D third location high, second location low.
// - index 0x199 holds channel D fifth location high, fourth location low.
// - locations are eight-bit, read-only, zero after reset.
// - index 0x19A holds channel A second and first amplitude; bits 15,7 zero.
// - index 0x19B holds channel A fourth and third amplitude; reserved bits zero.
// - index 0x19C holds channel B first and channel A fifth amplitude.
// - index 0x19D holds channel B third and second amplitude.
// - index 0x19E holds channel B fifth and fourth amplitude.
// - amplitudes are seven-bit, read-only, zero after reset.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module crpr_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [crpr_pkg::CRPR_ADDR_W-1:0] paddr,
	input wire logic [crpr_pkg::CRPR_DATA_W-1:0] pwdata,
	output logic [crpr_pkg::CRPR_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// results from the reflectometry engine
	input wire logic result_load,
	input wire logic [crpr_pkg::CRPR_POS_W-1:0] new_reflect_pos_d_second,
	input wire logic [crpr_pkg::CRPR_POS_W-1:0] new_reflect_pos_d_third,
	input wire logic [crpr_pkg::CRPR_POS_W-1:0] new_reflect_pos_d_fourth,
	input wire logic [crpr_pkg::CRPR_POS_W-1:0] new_reflect_pos_d_fifth,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_a_first,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_a_second,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_a_third,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_a_fourth,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_a_fifth,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_b_first,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_b_second,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_b_third,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_b_fourth,
	input wire logic [crpr_pkg::CRPR_MAG_W-1:0] new_reflect_mag_b_fifth,
	// status toward the engine
	output logic result_hold,
	output logic results_valid
);
	import crpr_pkg::*;

	localparam int POS_BITS = CRPR_POS_N * CRPR_POS_W;
	localparam int MAG_BITS = CRPR_MAG_N * CRPR_MAG_W;

	crpr_apb_state_e state_q;
	logic setup_take;
	logic [CRPR_IDX_W-1:0] idx;
	logic aligned;
	logic load_ok;
	logic wr_ctrl;
	logic [POS_BITS-1:0] pos_in;
	logic [MAG_BITS-1:0] mag_in;
	logic [POS_BITS-1:0] pos_q;
	logic [MAG_BITS-1:0] mag_q;
	logic [CRPR_DATA_W-1:0] prdata_q;
	logic [CRPR_DATA_W-1:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;
	logic hold_q;
	logic hold_d;
	logic valid_q;
	logic valid_d;
	logic miss_q;
	logic miss_d;

	// pack two amplitudes with their reserved bits forced low
	function automatic logic [CRPR_DATA_W-1:0] pair_mag(
		input logic [CRPR_MAG_W-1:0] hi,
		input logic [CRPR_MAG_W-1:0] lo
	);
		pair_mag = {16'h0000, 1'b0, hi, 1'b0, lo};
	endfunction

	// pack two locations into the low half word
	function automatic logic [CRPR_DATA_W-1:0] pair_pos(
		input logic [CRPR_POS_W-1:0] hi,
		input logic [CRPR_POS_W-1:0] lo
	);
		pair_pos = {16'h0000, hi, lo};
	endfunction

	// true when an index names a register of this bank
	function automatic logic is_mapped(input logic [CRPR_IDX_W-1:0] i);
		is_mapped = ((i >= CRPR_IDX_POS_D_LO) && (i <= CRPR_IDX_MAG_B_2))
			|| (i == CRPR_IDX_CTRL);
	endfunction

	function automatic logic [CRPR_POS_W-1:0] pos_f(
		input logic [POS_BITS-1:0] v,
		input int k
	);
		pos_f = v[k*CRPR_POS_W +: CRPR_POS_W];
	endfunction

	function automatic logic [CRPR_MAG_W-1:0] mag_f(
		input logic [MAG_BITS-1:0] v,
		input int k
	);
		mag_f = v[k*CRPR_MAG_W +: CRPR_MAG_W];
	endfunction

	assign idx = paddr[CRPR_ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'b00);

	// field order: channel D second..fifth, then A first..fifth, B first..fifth
	assign pos_in = {new_reflect_pos_d_fifth, new_reflect_pos_d_fourth,
		new_reflect_pos_d_third, new_reflect_pos_d_second};
	assign mag_in = {new_reflect_mag_b_fifth, new_reflect_mag_b_fourth,
		new_reflect_mag_b_third, new_reflect_mag_b_second, new_reflect_mag_b_first,
		new_reflect_mag_a_fifth, new_reflect_mag_a_fourth, new_reflect_mag_a_third,
		new_reflect_mag_a_second, new_reflect_mag_a_first};

	// a held bank keeps the previous test's results for software to finish reading
	assign load_ok = result_load && !hold_q;

	crpr_apb_fsm u_fsm (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.state_q(state_q),
		.setup_take(setup_take),
		.pready(pready)
	);

	crpr_peak_store #(
		.N(CRPR_POS_N),
		.W(CRPR_POS_W),
		.RST(CRPR_POS_RST)
	) u_pos (
		.pclk(pclk),
		.presetn(presetn),
		.load_en(load_ok),
		.load_data(pos_in),
		.fields_q(pos_q)
	);

	crpr_peak_store #(
		.N(CRPR_MAG_N),
		.W(CRPR_MAG_W),
		.RST(CRPR_MAG_RST)
	) u_mag (
		.pclk(pclk),
		.presetn(presetn),
		.load_en(load_ok),
		.load_data(mag_in),
		.fields_q(mag_q)
	);

	// read data and error are sampled in the setup cycle and held through access
	always_comb begin
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (setup_take) begin
			pslverr_d = !(aligned && is_mapped(idx));
			prdata_d = CRPR_RDATA_RST;
			if (aligned && !pwrite) begin
				case (idx)
					CRPR_IDX_POS_D_LO: begin
						prdata_d = pair_pos(pos_f(pos_q, 1), pos_f(pos_q, 0));
					end
					CRPR_IDX_POS_D_HI: begin
						prdata_d = pair_pos(pos_f(pos_q, 3), pos_f(pos_q, 2));
					end
					CRPR_IDX_MAG_A_1: begin
						prdata_d = pair_mag(mag_f(mag_q, 1), mag_f(mag_q, 0));
					end
					CRPR_IDX_MAG_A_2: begin
						prdata_d = pair_mag(mag_f(mag_q, 3), mag_f(mag_q, 2));
					end
					CRPR_IDX_MAG_AB: begin
						prdata_d = pair_mag(mag_f(mag_q, 5), mag_f(mag_q, 4));
					end
					CRPR_IDX_MAG_B_1: begin
						prdata_d = pair_mag(mag_f(mag_q, 7), mag_f(mag_q, 6));
					end
					CRPR_IDX_MAG_B_2: begin
						prdata_d = pair_mag(mag_f(mag_q, 9), mag_f(mag_q, 8));
					end
					CRPR_IDX_CTRL: begin
						prdata_d[CRPR_CTRL_HOLD_BIT] = hold_q;
						prdata_d[CRPR_STAT_VALID_BIT] = valid_q;
						prdata_d[CRPR_STAT_MISS_BIT] = miss_q;
					end
					default: begin
						prdata_d = CRPR_RDATA_RST;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= CRPR_RDATA_RST;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// writes reach only the control word; result indexes take no write
	assign wr_ctrl = pready && pwrite && aligned && (idx == CRPR_IDX_CTRL);

	// control and status: missed-load flag set wins over a write-one clear
	always_comb begin
		hold_d = hold_q;
		valid_d = valid_q || load_ok;
		miss_d = miss_q;
		if (wr_ctrl) begin
			hold_d = pwdata[CRPR_CTRL_HOLD_BIT];
			if (pwdata[CRPR_STAT_MISS_BIT]) begin
				miss_d = 1'b0;
			end
		end
		if (result_load && hold_q) begin
			miss_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 1'b0;
			valid_q <= 1'b0;
			miss_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			valid_q <= valid_d;
			miss_q <= miss_d;
		end
	end

	assign result_hold = hold_q;
	assign results_valid = valid_q;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// the tracker still shows setup during the access cycle, it moves on at the access edge
	logic rd_acc;
	assign rd_acc = pready && !pwrite && aligned && (state_q == CRPR_ST_SETUP);

	chk_loc_lo_word: assert property (
		rd_acc && idx == CRPR_IDX_POS_D_LO |-> prdata == {16'h0000, $past(pos_q[15:8]),
			$past(pos_q[7:0])})
		else $error("location low word mismatch");

	chk_loc_hi_word: assert property (
		rd_acc && idx == CRPR_IDX_POS_D_HI |-> prdata == {16'h0000, $past(pos_q[31:24]),
			$past(pos_q[23:16])})
		else $error("location high word mismatch");

	chk_loc_hold_stable: assert property (
		!load_ok |=> $stable(pos_q))
		else $error("location changed without a load");

	chk_amp_a_first: assert property (
		rd_acc && idx == CRPR_IDX_MAG_A_1 |-> prdata[15] == 1'b0 && prdata[7] == 1'b0
			&& prdata[14:8] == $past(mag_q[13:7]) && prdata[6:0] == $past(mag_q[6:0]))
		else $error("channel A first pair mismatch");

	chk_amp_a_second: assert property (
		rd_acc && idx == CRPR_IDX_MAG_A_2 |-> prdata == {17'h00000, $past(mag_q[27:21]),
			1'b0, $past(mag_q[20:14])})
		else $error("channel A second pair mismatch");

	chk_amp_ab_pair: assert property (
		rd_acc && idx == CRPR_IDX_MAG_AB |-> prdata[14:8] == $past(mag_q[41:35])
			&& prdata[6:0] == $past(mag_q[34:28]) && prdata[31:15] == 17'h00000)
		else $error("mixed A and B pair mismatch");

	chk_amp_b_first: assert property (
		rd_acc && idx == CRPR_IDX_MAG_B_1 |-> prdata[14:8] == $past(mag_q[55:49])
			&& prdata[6:0] == $past(mag_q[48:42]) && prdata[7] == 1'b0)
		else $error("channel B first pair mismatch");

	chk_amp_b_second: assert property (
		rd_acc && idx == CRPR_IDX_MAG_B_2 |-> prdata[14:8] == $past(mag_q[69:63])
			&& prdata[6:0] == $past(mag_q[62:56]) && prdata[15] == 1'b0)
		else $error("channel B second pair mismatch");

	chk_amp_load_path: assert property (
		load_ok |=> mag_q == $past(mag_in) && pos_q == $past(pos_in))
		else $error("results not taken on load");

	chk_write_ignored: assert property (
		pready && pwrite && !load_ok |=> $stable(mag_q) && $stable(pos_q))
		else $error("write disturbed stored results");

	cov_read_loc: cover property (rd_acc && idx == CRPR_IDX_POS_D_LO);
	cov_held_load: cover property (hold_q && result_load ##1 miss_q);
	cov_load_then_read: cover property (load_ok ##[1:20] rd_acc && idx == CRPR_IDX_MAG_AB);

endmodule

//--- verif/crpr_top_tb_top.sv
// self-checking testbench for the cable reflection peak result bank
`timescale 1ns/10ps
module crpr_top_tb_top;
	import crpr_pkg::*;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [CRPR_ADDR_W-1:0] paddr = '0;
	logic [CRPR_DATA_W-1:0] pwdata = '0;
	logic [CRPR_DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic result_load = 1'b0;
	logic [CRPR_POS_W-1:0] lp[4] = '{default: '0};
	logic [CRPR_MAG_W-1:0] lm[10] = '{default: '0};
	logic result_hold;
	logic results_valid;
	// expected field values and control state
	logic [CRPR_POS_W-1:0] mp[4] = '{default: '0};
	logic [CRPR_MAG_W-1:0] mm[10] = '{default: '0};
	logic hold_m = 1'b0;
	logic miss_m = 1'b0;
	logic valid_m = 1'b0;
	// each note: read flag, expected pslverr, expected prdata
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] rng_q = 32'hAF17;
	int err_count = 0;
	int num_checks = 0;
	int cyc_count = 0;

	always #5 pclk = ~pclk;

	crpr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .result_load(result_load),
		.new_reflect_pos_d_second(lp[0]), .new_reflect_pos_d_third(lp[1]),
		.new_reflect_pos_d_fourth(lp[2]), .new_reflect_pos_d_fifth(lp[3]),
		.new_reflect_mag_a_first(lm[0]), .new_reflect_mag_a_second(lm[1]),
		.new_reflect_mag_a_third(lm[2]), .new_reflect_mag_a_fourth(lm[3]),
		.new_reflect_mag_a_fifth(lm[4]), .new_reflect_mag_b_first(lm[5]),
		.new_reflect_mag_b_second(lm[6]), .new_reflect_mag_b_third(lm[7]),
		.new_reflect_mag_b_fourth(lm[8]), .new_reflect_mag_b_fifth(lm[9]),
		.result_hold(result_hold), .results_valid(results_valid));

	function automatic logic [31:0] xs();
		rng_q = rng_q ^ (rng_q << 13);
		rng_q = rng_q ^ (rng_q >> 17);
		rng_q = rng_q ^ (rng_q << 5);
		return rng_q;
	endfunction

	function automatic logic [31:0] exp_reg(input int r);
		case (r)
			0: return {16'h0000, mp[1], mp[0]};
			1: return {16'h0000, mp[3], mp[2]};
			2: return {16'h0000, 1'b0, mm[1], 1'b0, mm[0]};
			3: return {16'h0000, 1'b0, mm[3], 1'b0, mm[2]};
			4: return {16'h0000, 1'b0, mm[5], 1'b0, mm[4]};
			5: return {16'h0000, 1'b0, mm[7], 1'b0, mm[6]};
			default: return {16'h0000, 1'b0, mm[9], 1'b0, mm[8]};
		endcase
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; the expectation is noted before the request goes out
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
		input logic [31:0] exp, input logic err);
		exp_q.push_back({~wr, err, exp});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic read_all();
		for (int r = 0; r < 7; r++) begin
			apb(1'b0, 12'h660 + 12'(4 * r), 32'h0, exp_reg(r), 1'b0);
		end
	endtask

	task automatic read_ctrl();
		apb(1'b0, 12'h6C0, 32'h0, {22'h0, miss_m, valid_m, 7'h00, hold_m}, 1'b0);
	endtask

	// n loads on consecutive cycles, then inverted location inputs with the strobe low
	task automatic load(input int n);
		logic [31:0] v;
		logic [CRPR_POS_W-1:0] vp[4];
		logic [CRPR_MAG_W-1:0] vm[10];
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			result_load <= 1'b1;
			for (int k = 0; k < 4; k++) begin
				v = xs();
				vp[k] = v[7:0];
				lp[k] <= vp[k];
			end
			for (int k = 0; k < 10; k++) begin
				v = xs();
				vm[k] = v[6:0];
				lm[k] <= vm[k];
			end
			if (hold_m) begin
				miss_m = 1'b1;
			end else begin
				mp = vp;
				mm = vm;
				valid_m = 1'b1;
			end
		end
		@(posedge pclk);
		result_load <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			lp[k] <= ~lp[k];
		end
	endtask

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		mp = '{default: '0};
		mm = '{default: '0};
		{hold_m, miss_m, valid_m} = 3'b000;
	endtask

	// result watcher: an access edge with pready high completes a transfer
	always @(posedge pclk) begin
		if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'hFFFF_FFFF, 32'h0);
			end else begin
				e = exp_q.pop_front();
				if (e[33]) begin
					check(prdata, e[31:0]);
				end
				check({31'h0, pslverr}, {31'h0, e[32]});
			end
		end
	end

	always @(posedge pclk) begin
		cyc_count++;
		if (cyc_count == 5000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		read_all();
		read_ctrl();
		check({31'h0, results_valid}, 32'h0);
		load(1);
		read_all();
		check({31'h0, results_valid}, 32'h1);
		load(2);
		read_all();
		for (int r = 0; r < 7; r++) begin
			apb(1'b1, 12'h660 + 12'(4 * r), xs(), 32'h0, 1'b0);
		end
		read_all();
		apb(1'b0, 12'h67C, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h65C, xs(), 32'h0, 1'b1);
		apb(1'b0, 12'h661, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h6C0, 32'h1, 32'h0, 1'b0);
		hold_m = 1'b1;
		// the hold bit is launched by the access edge just passed; look once it has settled
		@(negedge pclk);
		check({31'h0, result_hold}, 32'h1);
		load(1);
		read_all();
		read_ctrl();
		apb(1'b1, 12'h6C0, 32'h200, 32'h0, 1'b0);
		{hold_m, miss_m} = 2'b00;
		read_ctrl();
		check({31'h0, result_hold}, 32'h0);
		repeat (4) begin
			load(1);
			read_all();
		end
		do_reset();
		read_all();
		read_ctrl();
		check({31'h0, results_valid}, 32'h0);
		report_and_stop();
	end
endmodule
